// *** core/vae_defs.svh ***
// Constants for the voice activity energy front end
`ifndef VAE_DEFS_SVH
`define VAE_DEFS_SVH
`define VAE_FRAME_TIME_MS   20
`define VAE_LAGS            9
`define VAE_AVG_FRAMES      4
`define VAE_ACF_W           32
`define VAE_PRED_W          16
`define VAE_AVG_W           34
`define VAE_ENERGY_W        56
`define VAE_FIFO_DEPTH      8
`define VAE_BURST_MIN       3
`define VAE_HANG_FRAMES     5
`define VAE_HIST_RST        34'h000000000
`define VAE_ACF_RST         32'h00000000
`define VAE_THR_RST         56'h00000000000000
`define VAE_PRED0_RST       16'h0001
`define VAE_PREDN_RST       16'h0000
`endif

// *** core/vae_pkg.sv ***
// Types for the voice activity energy front end
`include "vae_defs.svh"
package vae_pkg;
	typedef logic signed [`VAE_ACF_W-1:0]    vae_acf_t;
	typedef logic signed [`VAE_PRED_W-1:0]   vae_pred_t;
	typedef logic signed [`VAE_AVG_W-1:0]    vae_avg_t;
	typedef logic signed [`VAE_ENERGY_W-1:0] vae_energy_t;
	typedef vae_acf_t  [`VAE_LAGS-1:0] vae_acf_vec_t;
	typedef vae_pred_t [`VAE_LAGS-1:0] vae_pred_vec_t;
	typedef vae_avg_t  [`VAE_LAGS-1:0] vae_avg_vec_t;
	typedef enum logic [3:0] {
		VAE_IDLE   = 4'h1,
		VAE_AVG    = 4'h2,
		VAE_DECIDE = 4'h4,
		VAE_DONE   = 4'h8
	} vae_state_t;
endpackage

// *** core/vae_stream_if.sv ***
// Valid/ready stream carrier between internal modules
`timescale 1ns/1ps
`default_nettype none
interface vae_stream_if #(
	parameter int W = 8
);
	logic         valid;
	logic         ready;
	logic [W-1:0] data;
	modport src (output valid, output data, input ready);
	modport snk (input valid, input data, output ready);
endinterface
`default_nettype wire

// *** core/vae_fifo.sv ***
// Parameterised synchronous FIFO with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module vae_fifo #(
	parameter int W     = 8,
	parameter int DEPTH = 8
) (
	// Clock and reset
	input  wire logic clk_sys,
	input  wire logic rst_n,
	// Fill side
	vae_stream_if.snk wr,
	// Drain side
	vae_stream_if.src rd
);
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam logic [AW:0] FULL_CNT = (AW + 1)'(DEPTH);
	localparam logic [AW-1:0] LAST   = AW'(DEPTH - 1);

	logic [W-1:0]  mem [DEPTH];
	logic [AW-1:0] wp_q;
	logic [AW-1:0] rp_q;
	logic [AW:0]   cnt_q;
	wire           push;
	wire           pop;

	assign wr.ready = (cnt_q != FULL_CNT);
	assign rd.valid = (cnt_q != '0);
	assign rd.data  = mem[rp_q];
	assign push     = wr.valid && wr.ready;
	assign pop      = rd.valid && rd.ready;

	always_ff @(posedge clk_sys) begin
		if (push) begin
			mem[wp_q] <= wr.data;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			wp_q  <= '0;
			rp_q  <= '0;
			cnt_q <= '0;
		end else begin
			if (push) begin
				wp_q <= (wp_q == LAST) ? '0 : wp_q + 1'b1;
			end
			if (pop) begin
				rp_q <= (rp_q == LAST) ? '0 : rp_q + 1'b1;
			end
			if (push && !pop) begin
				cnt_q <= cnt_q + 1'b1;
			end else if (pop && !push) begin
				cnt_q <= cnt_q - 1'b1;
			end
		end
	end
endmodule
`default_nettype wire

// *** core/vae_front.sv ***
// Voice activity energy front end: averaging, energy and decision
`timescale 1ns/1ps
`default_nettype none
`include "vae_defs.svh"
module vae_front
	import vae_pkg::*;
#(
	parameter int FIFO_DEPTH  = `VAE_FIFO_DEPTH,
	parameter int BURST_MIN   = `VAE_BURST_MIN,
	parameter int HANG_FRAMES = `VAE_HANG_FRAMES
) (
	// Clock and reset
	input  wire logic          clk_sys,
	input  wire logic          rst_n,
	// Frame input from the speech encoder
	input  wire logic          frame_valid,
	input  wire vae_acf_vec_t  frame_autocorr,
	output logic               frame_ready,
	// Per-frame condition flags from neighbouring detectors
	input  wire logic          stationary,
	input  wire logic          pitch_present,
	input  wire logic          tone_present,
	// Predictor values derived outside from the delayed average
	input  wire vae_pred_vec_t avg_predictor_autocorr,
	// Threshold values
	input  wire vae_energy_t   next_threshold,
	input  wire vae_acf_t      low_energy_limit,
	input  wire vae_energy_t   low_level_threshold,
	// Averages out
	output vae_avg_vec_t       recent_avg_autocorr,
	output vae_avg_vec_t       delayed_avg_autocorr,
	output logic               avg_valid,
	// Energy and decisions out
	output vae_energy_t        filtered_energy,
	output vae_energy_t        adaptive_threshold,
	output vae_pred_vec_t      filter_predictor_autocorr,
	output logic               raw_decision,
	output logic               final_decision,
	output logic               decision_valid
);
	localparam int LAGS  = `VAE_LAGS;
	localparam int NPREV = `VAE_AVG_FRAMES - 1;
	localparam int NAVG  = `VAE_AVG_FRAMES;
	localparam int VW    = LAGS * `VAE_ACF_W;
	localparam int EW    = `VAE_ENERGY_W;
	localparam int AVW   = `VAE_AVG_W;
	localparam int CW    = 8;
	localparam logic [CW-1:0] BURST_CNT = CW'(BURST_MIN);
	localparam logic [CW-1:0] HANG_CNT  = CW'(HANG_FRAMES);

	// Internal stream carriers around the frame FIFO
	vae_stream_if #(.W(VW)) in_s ();
	vae_stream_if #(.W(VW)) out_s ();

	vae_state_t    state_q;
	vae_state_t    state_d;
	vae_acf_vec_t  cur_q;
	vae_acf_vec_t  prev_q [NPREV];
	vae_avg_vec_t  hist_q [NAVG];
	vae_avg_vec_t  recent_q;
	vae_avg_vec_t  delayed_q;
	vae_avg_vec_t  recent_d;
	vae_energy_t   energy_q;
	vae_energy_t   energy_d;
	vae_energy_t   thr_q;
	vae_energy_t   thr_d;
	vae_pred_vec_t pred_q;
	logic          raw_q;
	logic          final_q;
	logic          avg_valid_q;
	logic          dec_valid_q;
	logic [CW-1:0] burst_q;
	logic [CW-1:0] hang_q;
	logic [CW-1:0] burst_d;
	logic [CW-1:0] hang_d;
	vae_energy_t   prod [LAGS];

	wire           take;
	wire           in_avg;
	wire           in_decide;
	wire           raw_now;
	wire           low_level;
	wire           adapt_ok;
	wire           final_now;
	wire           thr_load;
	wire           pred_load;

	assign in_s.valid  = frame_valid;
	assign in_s.data   = frame_autocorr;
	assign frame_ready = in_s.ready;

	vae_fifo #(
		.W     (VW),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.clk_sys (clk_sys),
		.rst_n   (rst_n),
		.wr      (in_s),
		.rd      (out_s)
	);

	assign out_s.ready = (state_q == VAE_IDLE);
	assign take        = out_s.valid && out_s.ready;
	assign in_avg      = (state_q == VAE_AVG);
	assign in_decide   = (state_q == VAE_DECIDE);

	// Per-lag products, doubled above lag zero
	genvar gi;
	generate
		for (gi = 0; gi < LAGS; gi++) begin : g_lag
			wire vae_energy_t pe;
			wire vae_energy_t ae;
			wire vae_energy_t pa;
			assign pe = {{(EW - `VAE_PRED_W){pred_q[gi][`VAE_PRED_W-1]}}, pred_q[gi]};
			assign ae = {{(EW - `VAE_ACF_W){cur_q[gi][`VAE_ACF_W-1]}}, cur_q[gi]};
			assign pa = EW'(pe * ae);
			assign prod[gi] = (gi == 0) ? pa : EW'(pa <<< 1);
			// Current frame plus three preceding ones
			assign recent_d[gi] = AVW'({{2{cur_q[gi][`VAE_ACF_W-1]}}, cur_q[gi]})
				+ AVW'({{2{prev_q[0][gi][`VAE_ACF_W-1]}}, prev_q[0][gi]})
				+ AVW'({{2{prev_q[1][gi][`VAE_ACF_W-1]}}, prev_q[1][gi]})
				+ AVW'({{2{prev_q[2][gi][`VAE_ACF_W-1]}}, prev_q[2][gi]});
		end
	endgenerate

	always_comb begin
		energy_d = '0;
		for (int i = 0; i < LAGS; i++) begin
			energy_d = energy_d + prod[i];
		end
	end

	assign raw_now   = (energy_q > thr_q);
	// Very quiet frames use the fixed level
	assign low_level = (cur_q[0] < low_energy_limit);
	// Adapt only without speech, stationary, unvoiced
	assign adapt_ok  = !raw_now && !final_q && stationary && !pitch_present
		&& !tone_present;

	always_comb begin
		burst_d = burst_q;
		hang_d  = hang_q;
		if (raw_now) begin
			burst_d = (burst_q == 8'hFF) ? burst_q : burst_q + 1'b1;
			if (burst_d >= BURST_CNT) begin
				hang_d = HANG_CNT;
			end
		end else begin
			burst_d = '0;
			if (hang_q != '0) begin
				hang_d = hang_q - 1'b1;
			end
		end
	end

	// Final decision adds hangover to raw
	assign final_now = raw_now || (!raw_now && hang_q != '0);

	// Four-cycle frame sequence: take, average, decide, done
	always_comb begin
		state_d = state_q;
		case (state_q)
			VAE_IDLE: begin
				if (take) begin
					state_d = VAE_AVG;
				end
			end
			VAE_AVG: begin
				state_d = VAE_DECIDE;
			end
			VAE_DECIDE: begin
				state_d = VAE_DONE;
			end
			VAE_DONE: begin
				state_d = VAE_IDLE;
			end
			default: begin
				state_d = VAE_IDLE;
			end
		endcase
	end

	// Popped frame held until the next take
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			state_q <= VAE_IDLE;
			cur_q   <= '{default: `VAE_ACF_RST};
		end else begin
			state_q <= state_d;
			if (take) begin
				cur_q <= out_s.data;
			end
		end
	end

	// Four-frame history, all zero from reset
	// Oldest stored average becomes delayed average
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			for (int k = 0; k < NPREV; k++) begin
				prev_q[k] <= '{default: `VAE_ACF_RST};
			end
			for (int k = 0; k < NAVG; k++) begin
				hist_q[k] <= '{default: `VAE_HIST_RST};
			end
			recent_q  <= '{default: `VAE_HIST_RST};
			delayed_q <= '{default: `VAE_HIST_RST};
		end else if (in_avg) begin
			prev_q[0] <= cur_q;
			for (int k = 1; k < NPREV; k++) begin
				prev_q[k] <= prev_q[k-1];
			end
			hist_q[0] <= recent_d;
			for (int k = 1; k < NAVG; k++) begin
				hist_q[k] <= hist_q[k-1];
			end
			recent_q  <= recent_d;
			delayed_q <= hist_q[NAVG-1];
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			energy_q    <= `VAE_THR_RST;
			avg_valid_q <= 1'b0;
		end else begin
			avg_valid_q <= in_avg;
			if (in_avg) begin
				energy_q <= energy_d;
			end
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			raw_q       <= 1'b0;
			final_q     <= 1'b0;
			dec_valid_q <= 1'b0;
		end else begin
			dec_valid_q <= in_decide;
			if (in_decide) begin
				raw_q   <= raw_now;
				final_q <= final_now;
			end
		end
	end

	// Burst and hangover counters step per decision
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			burst_q <= '0;
			hang_q  <= '0;
		end else if (in_decide) begin
			burst_q <= burst_d;
			hang_q  <= hang_d;
		end
	end

	// Threshold loads only in the decide cycle
	assign thr_load  = in_decide && (low_level || adapt_ok);
	assign thr_d     = low_level ? low_level_threshold : next_threshold;
	assign pred_load = in_decide && !low_level && adapt_ok;

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			thr_q <= `VAE_THR_RST;
		end else if (thr_load) begin
			thr_q <= thr_d;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			pred_q[0] <= `VAE_PRED0_RST;
			for (int k = 1; k < LAGS; k++) begin
				pred_q[k] <= `VAE_PREDN_RST;
			end
		end else if (pred_load) begin
			pred_q <= avg_predictor_autocorr;
		end
	end

	assign recent_avg_autocorr       = recent_q;
	assign delayed_avg_autocorr      = delayed_q;
	assign avg_valid                 = avg_valid_q;
	assign filtered_energy           = energy_q;
	assign adaptive_threshold        = thr_q;
	assign filter_predictor_autocorr = pred_q;
	assign raw_decision              = raw_q;
	assign final_decision            = final_q;
	assign decision_valid            = dec_valid_q;
endmodule
`default_nettype wire

// *** dv/vae_front_chk.sv ***
// Checker for the energy front end ports
`timescale 1ns/1ps
`default_nettype none
module vae_front_chk
	import vae_pkg::*;
(
	// Clock and reset
	input wire logic        clk_sys,
	input wire logic        rst_n,
	// Flow
	input wire logic        frame_valid,
	input wire logic        frame_ready,
	input wire logic        avg_valid,
	input wire logic        decision_valid,
	// Conditions
	input wire logic        stationary,
	input wire logic        pitch_present,
	input wire logic        tone_present,
	input wire vae_energy_t low_level_threshold,
	// Results
	input wire vae_energy_t filtered_energy,
	input wire vae_energy_t adaptive_threshold,
	input wire logic        raw_decision,
	input wire logic        final_decision
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	sequence s_dec_pulse;
		##1 decision_valid ##1 !decision_valid;
	endsequence
	property p_hold(c);
		c && decision_valid && adaptive_threshold != low_level_threshold
			|-> $stable(adaptive_threshold);
	endproperty
	chk_raw_compare: assert property (decision_valid |->
		raw_decision == (filtered_energy > $past(adaptive_threshold)))
		else $error("raw decision disagrees with energy");
	chk_final_cover: assert property (decision_valid && raw_decision |-> final_decision)
		else $error("final decision below raw");
	chk_tone_block: assert property (p_hold($past(tone_present)))
		else $error("threshold moved during tone");
	chk_speech_block: assert property (p_hold(raw_decision || $past(pitch_present || !stationary)))
		else $error("threshold moved without quiet frame");
	chk_frame_flow: assert property (avg_valid |-> s_dec_pulse)
		else $error("decision pulse missing after averages");
	chk_dec_spacing: assert property (decision_valid |=> !decision_valid [*3])
		else $error("decisions closer than four cycles");
	chk_take_answer: assert property (frame_valid && frame_ready |-> ##[2:40] avg_valid)
		else $error("taken frame got no answer");
	chk_energy_hold: assert property ($changed(filtered_energy) |-> avg_valid)
		else $error("energy changed between frames");
	chk_thr_moment: assert property ($changed(adaptive_threshold) |-> decision_valid)
		else $error("threshold changed outside decision");
endmodule
bind vae_front vae_front_chk i_vae_front_chk (.clk_sys, .rst_n, .frame_valid, .frame_ready,
	.avg_valid, .decision_valid, .stationary, .pitch_present, .tone_present,
	.low_level_threshold, .filtered_energy, .adaptive_threshold, .raw_decision,
	.final_decision);
`default_nettype wire

// *** dv/vae_enc_model.sv ***
// Speech encoder stand-in offering autocorrelation frames
`timescale 1ns/1ps
`default_nettype none
module vae_enc_model
	import vae_pkg::*;
(
	// Clock
	input  wire logic        clk_sys,
	// Frame handshake
	input  wire logic        frame_ready,
	output var logic         frame_valid,
	output var vae_acf_vec_t frame_autocorr
);
	int q[$];
	// Queue a frame whose lag i carries v + i
	task automatic send(input int v);
		q.push_back(v);
	endtask
	initial begin
		frame_valid = 1'b0;
		frame_autocorr = '0;
	end
	always @(posedge clk_sys) begin
		if (frame_valid && frame_ready)
			q.delete(0);
		#1;
		frame_valid = (q.size() != 0);
		for (int i = 0; i < 9; i++)
			frame_autocorr[i] = frame_valid ? vae_acf_t'(q[0] + i) : ~frame_autocorr[i];
	end
endmodule
`default_nettype wire

// *** dv/test_vae_front.sv ***
// Self-checking bench for the energy front end
`timescale 1ns/1ps
`default_nettype none
module test_vae_front
	import vae_pkg::*;
;
	logic          clk_sys, rst_n, stationary, pitch_present, tone_present;
	logic          frame_valid, frame_ready, avg_valid, decision_valid;
	logic          raw_decision, final_decision;
	vae_acf_vec_t  frame_autocorr;
	vae_pred_vec_t avg_predictor_autocorr, filter_predictor_autocorr;
	vae_energy_t   next_threshold, low_level_threshold, filtered_energy, adaptive_threshold;
	vae_acf_t      low_energy_limit;
	vae_avg_vec_t  recent_avg_autocorr, delayed_avg_autocorr;
	int            err_total, num_checks, cyc, nav;
	longint        acc[$], rec[$], msum;
	vae_front i_vae_front (.clk_sys, .rst_n, .frame_valid, .frame_autocorr, .frame_ready,
		.stationary, .pitch_present, .tone_present, .avg_predictor_autocorr,
		.next_threshold, .low_energy_limit, .low_level_threshold, .recent_avg_autocorr,
		.delayed_avg_autocorr, .avg_valid, .filtered_energy, .adaptive_threshold,
		.filter_predictor_autocorr, .raw_decision, .final_decision, .decision_valid);
	vae_enc_model i_vae_enc_model (.clk_sys, .frame_ready, .frame_valid, .frame_autocorr);
	initial begin
		clk_sys = 1'b0;
		forever #2.5 clk_sys = ~clk_sys;
	end
	task automatic cmp(input string n, input logic signed [55:0] e, input logic signed [55:0] g);
		num_checks++;
		if (g !== e) begin
			err_total++;
			$display("MISMATCH %s expected %0d seen %0d", n, e, g);
		end
	endtask
	task automatic summarize;
		$display("checks %0d mismatches %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	always @(posedge clk_sys) begin
		cyc++;
		if (cyc == 2000) begin
			err_total++;
			summarize();
		end
	end
	// Reference sums of accepted frames
	always @(posedge clk_sys) begin
		if (rst_n && frame_valid && frame_ready)
			acc.push_back(frame_autocorr[0]);
		#1;
		if (avg_valid === 1'b1) begin
			msum = 0;
			for (int j = 0; j < 4 && j <= nav; j++)
				msum += acc[nav - j];
			rec.push_back(msum);
			cmp("recent0", msum, recent_avg_autocorr[0]);
			cmp("recent8", msum + 8 * (nav < 3 ? nav + 1 : 4), recent_avg_autocorr[8]);
			cmp("delayed0", nav < 4 ? 0 : rec[nav - 4], delayed_avg_autocorr[0]);
			nav++;
		end
	end
	task automatic frm(input int v);
		int n;
		i_vae_enc_model.send(v);
		n = 0;
		do begin
			@(posedge clk_sys);
			#1;
			n++;
		end while (decision_valid !== 1'b1 && n < 40);
		cmp("decided", 1, decision_valid);
	endtask
	task automatic t_reset;
		cmp("ready", 1, frame_ready);
		cmp("energy", 0, filtered_energy);
		cmp("pred0", 1, filter_predictor_autocorr[0]);
		cmp("thr", 0, adaptive_threshold);
		cmp("delayed8", 0, delayed_avg_autocorr[8]);
		$display("test reset done");
	endtask
	task automatic t_adapt;
		stationary = 1'b1;
		frm(0);
		cmp("energy", 0, filtered_energy);
		cmp("raw", 0, raw_decision);
		cmp("thr", 100, adaptive_threshold);
		cmp("pred0", 2, filter_predictor_autocorr[0]);
		cmp("pred8", 1, filter_predictor_autocorr[8]);
		next_threshold = 56'h000000000000C8;
		$display("test adapt done");
	endtask
	task automatic t_block;
		logic [2:0] c[3] = '{3'b000, 3'b110, 3'b101};
		for (int k = 0; k < 3; k++) begin
			{stationary, pitch_present, tone_present} = c[k];
			frm(1);
			cmp("energy", 18 + 72, filtered_energy);
			cmp("raw", 0, raw_decision);
			cmp("thr", 100, adaptive_threshold);
		end
		{stationary, pitch_present, tone_present} = 3'b000;
		$display("test block done");
	endtask
	task automatic t_low;
		low_energy_limit = 32'h00000100;
		frm(2);
		cmp("thr", 48, adaptive_threshold);
		cmp("raw", 1, raw_decision);
		low_energy_limit = 32'h00000000;
		$display("test low level done");
	endtask
	task automatic t_hang;
		logic [12:0] loud = 13'h0076;
		logic [12:0] fin = 13'h0FF6;
		for (int i = 0; i < 13; i++) begin
			frm(loud[i] ? 10 : -4);
			cmp("raw", loud[i], raw_decision);
			cmp("final", fin[i], final_decision);
		end
		$display("test hangover done");
	endtask
	task automatic t_fifo;
		int n;
		int base;
		bit refused;
		base = nav;
		refused = 1'b0;
		n = 0;
		for (int i = 0; i < 14; i++)
			i_vae_enc_model.send(3);
		while (nav < base + 14 && n < 300) begin
			@(posedge clk_sys);
			#1;
			n++;
			if (frame_ready === 1'b0)
				refused = 1'b1;
		end
		repeat (3) @(posedge clk_sys);
		#1;
		cmp("refused", 1, refused);
		cmp("frames", base + 14, nav);
		cmp("ready", 1, frame_ready);
		$display("test buffer done");
	endtask
	initial begin
		rst_n = 1'b0;
		{stationary, pitch_present, tone_present} = 3'b000;
		low_energy_limit = 32'h00000000;
		next_threshold = 56'h00000000000064;
		low_level_threshold = 56'h00000000000030;
		avg_predictor_autocorr = {9{16'h0001}};
		avg_predictor_autocorr[0] = 16'h0002;
		repeat (8) @(posedge clk_sys);
		#1 rst_n = 1'b1;
		t_reset();
		t_adapt();
		t_block();
		t_low();
		t_hang();
		t_fifo();
		summarize();
	end
endmodule
`default_nettype wire
